// ==== core/eeprom_cmd_pkg.sv ====
// constants of the serial memory command port: opcodes, status layout, timing
// assumes a 20 MHz system clock and a serial clock driven by the master
// Operation
// - guard low refuses array and status writes
// - guard fall clears latch, running cycle finishes
// - pause taken with clock low, select held
// - paused: inputs ignored, output floated, state kept
// - pause released with clock low resumes sequence
// - input sampled rising edge, msb first
// - first bit at first unpaused rise after select
// - read and write opcodes carry ninth address bit
// - set and clear latch opcodes
// - status read and status write opcodes
// - sequential read increments, wraps 1ffh to 0
// - latch set only by deselect after opcode
// - sixteen byte page, address wraps in page
// - write starts only at byte boundary deselect
// - array reads refused while busy, status answered
// - latch cleared by reset, commands, cycle end, guard
// - status byte layout: protect, latch, busy
// - busy flag high during cycle, read only
// - latch flag mirrors latch, not status writable
// - protect bits changed only by status write
// - deselect floats output, cycle continues
// - output updated after falling clock edge
// - protect levels none, quarter, half, all
// - write cycle lasts five milliseconds, busy set
package eeprom_cmd_pkg;
  localparam logic [7:0] READ_OP_MASK = 8'hf7;
  localparam logic [7:0] READ_OP = 8'h03;
  localparam logic [7:0] WRITE_OP = 8'h02;
  localparam logic [7:0] SET_LATCH_OP = 8'h06;
  localparam logic [7:0] CLEAR_LATCH_OP = 8'h04;
  localparam logic [7:0] STATUS_READ_OP = 8'h05;
  localparam logic [7:0] STATUS_WRITE_OP = 8'h01;
  localparam int NINTH_ADDR_POS = 3;
  localparam int PROT_HIGH_POS = 3;
  localparam int PROT_LOW_POS = 2;
  localparam int LATCH_POS = 1;
  localparam int BUSY_POS = 0;
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic [8:0] QUARTER_BASE = 9'h180;
  localparam logic [8:0] HALF_BASE = 9'h100;
  localparam logic [8:0] LAST_ADDR = 9'h1ff;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 512;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES_DEFAULT = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [2:0] PIN_RESET = 3'h7;
  localparam logic [1:0] FRAME_INSTR = 2'h0;
  localparam logic [1:0] FRAME_ADDR = 2'h1;
  localparam logic [1:0] FRAME_DATA = 2'h2;
endpackage

// ==== core/spi_eeprom_command_port.sv ====
// serial memory command front end: decoder, page buffer, latch, status, array
// assumes SCK only toggles while CS_N is low; MCLK runs free
`timescale 1ns/1ns
module spi_eeprom_command_port #(
  parameter int unsigned WRITE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLES_DEFAULT
) (
  // system
  input wire logic MCLK,
  input wire logic RST_N,
  // serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE
);
  import eeprom_cmd_pkg::*;

  function automatic logic is_read(input logic [7:0] op);
    return (op & READ_OP_MASK) == READ_OP;
  endfunction

  function automatic logic is_write(input logic [7:0] op);
    return (op & READ_OP_MASK) == WRITE_OP;
  endfunction

  // array lives in the system domain; link side reads it only while idle
  logic [7:0] mem [MEM_BYTES];

  // link domain state
  logic sof;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [1:0] frame, next_frame;
  logic [6:0] shreg, next_shreg;
  logic [7:0] cmd, next_cmd;
  logic [8:0] addr, next_addr;
  logic [7:0] out_byte, next_out_byte;
  logic out_en, next_out_en;
  logic [15:0] page_mask, next_page_mask;
  logic [1:0] sr_data, next_sr_data;
  logic [7:0] page_buf [PAGE_BYTES];
  logic page_we;
  logic [3:0] stat_s1, stat_s2;
  logic [2:0] eff_bit;
  logic [1:0] eff_frame;
  logic [7:0] full;
  logic [7:0] stat_byte;

  // system-side latch, busy, protect bits and cycle counter; all but the counter also read by the link crossing
  logic write_latch_flag, next_wel;
  logic busy, next_busy;
  logic [1:0] bp, next_bp;
  logic [16:0] wcnt, next_wcnt;
  logic mem_we;

  // frame start flag: select high arms it, first rising edge outside a pause clears it
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      sof <= 1'b1;
    end else if (HOLD_N) begin
      sof <= 1'b0;
    end
  end

  // two-stage crossing of busy, latch and protect bits into the link
  always_ff @(posedge SCK) begin
    stat_s1 <= {bp, write_latch_flag, busy};
    stat_s2 <= stat_s1;
  end

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[PROT_HIGH_POS] = stat_s2[3];
    stat_byte[PROT_LOW_POS] = stat_s2[2];
    stat_byte[LATCH_POS] = stat_s2[1];
    stat_byte[BUSY_POS] = stat_s2[0];
  end

  always_comb begin
    eff_bit = sof ? 3'h0 : bit_cnt;
    eff_frame = sof ? FRAME_INSTR : frame;
    full = {shreg, SI};
    next_bit_cnt = eff_bit + 3'h1;
    next_frame = eff_frame;
    next_shreg = full[6:0];
    next_cmd = cmd;
    next_addr = addr;
    next_out_byte = out_byte;
    next_out_en = sof ? 1'b0 : out_en;
    next_page_mask = sof ? 16'h0000 : page_mask;
    next_sr_data = sr_data;
    page_we = 1'b0;
    if (eff_bit == 3'h7) begin
      unique case (eff_frame)
        FRAME_INSTR: begin
          next_cmd = full;
          next_frame = FRAME_ADDR;
          next_addr[8] = full[NINTH_ADDR_POS];
          if (full == STATUS_READ_OP) begin
            next_out_byte = stat_byte;
            next_out_en = 1'b1;
          end
        end
        FRAME_ADDR: begin
          next_frame = FRAME_DATA;
          if (is_read(cmd) || is_write(cmd)) begin
            next_addr[7:0] = full;
          end
          if (is_read(cmd) && !stat_s2[0]) begin
            next_out_byte = mem[{addr[8], full}];
            next_out_en = 1'b1;
          end else if (cmd == STATUS_READ_OP) begin
            next_out_byte = stat_byte;
          end else if (cmd == STATUS_WRITE_OP) begin
            next_sr_data = full[PROT_HIGH_POS:PROT_LOW_POS];
          end
        end
        default: begin
          if (is_read(cmd) && out_en) begin
            next_addr = addr + 9'h001;
            next_out_byte = mem[next_addr];
          end else if (is_write(cmd)) begin
            page_we = 1'b1;
            next_page_mask[addr[3:0]] = 1'b1;
            next_addr[3:0] = addr[3:0] + 4'h1;
          end else if (cmd == STATUS_READ_OP) begin
            next_out_byte = stat_byte;
          end
        end
      endcase
    end
  end

  // paused: rising edges are simply not taken, all sequence state kept
  always_ff @(posedge SCK) begin
    if (HOLD_N) begin
      bit_cnt <= next_bit_cnt;
      frame <= next_frame;
      shreg <= next_shreg;
      cmd <= next_cmd;
      addr <= next_addr;
      out_byte <= next_out_byte;
      out_en <= next_out_en;
      page_mask <= next_page_mask;
      sr_data <= next_sr_data;
      if (page_we) begin
        page_buf[addr[3:0]] <= full;
      end
    end
  end

  // output bit changes on the falling edge, skipped while paused
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      SO <= 1'b0;
    end else if (HOLD_N) begin
      SO <= out_en & out_byte[~bit_cnt];
    end
  end

  // system domain: three-stage pin filter for {guard, pause, select}
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_f, next_pin_f;
  logic cs_prev;
  logic cs_f, hold_f, wp_f, cs_rise;
  // frame start flag crosses too, so a select pulse without clocks commits nothing
  logic sof_s1, sof_s2, sof_s3, sof_f, next_sof_f;
  logic frame_took, next_frame_took;

  always_comb begin
    next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
    next_sof_f = (sof_s2 & sof_s3) | (sof_f & (sof_s2 ^ sof_s3));
    next_frame_took = frame_took;
    if (!cs_f && cs_prev) begin
      next_frame_took = 1'b0;
    end
    // a bit taken wins over the select fall in the same cycle
    if (!cs_f && !sof_f) begin
      next_frame_took = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_s3 <= PIN_RESET;
      pin_f <= PIN_RESET;
      cs_prev <= 1'b1;
      sof_s1 <= 1'b1;
      sof_s2 <= 1'b1;
      sof_s3 <= 1'b1;
      sof_f <= 1'b1;
      frame_took <= 1'b0;
    end else begin
      pin_s1 <= {WP_N, HOLD_N, CS_N};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
      cs_prev <= pin_f[0];
      sof_s1 <= sof;
      sof_s2 <= sof_s1;
      sof_s3 <= sof_s2;
      sof_f <= next_sof_f;
      frame_took <= next_frame_took;
    end
  end

  assign cs_f = pin_f[0];
  assign hold_f = pin_f[1];
  assign wp_f = pin_f[2];
  assign cs_rise = cs_f & ~cs_prev;

  // frame-end decode; link state is frozen once select is high
  logic frame_clean, set_write_latch_cmd_done, clear_write_latch_cmd_done, status_write_cmd_done, write_done;
  logic page_locked, write_ok, status_write_cmd_ok;

  always_comb begin
    frame_clean = frame_took && bit_cnt == 3'h0;
    set_write_latch_cmd_done = frame_clean && frame == FRAME_ADDR && cmd == SET_LATCH_OP;
    clear_write_latch_cmd_done = frame_clean && frame == FRAME_ADDR && cmd == CLEAR_LATCH_OP;
    status_write_cmd_done = frame_clean && frame == FRAME_DATA && cmd == STATUS_WRITE_OP;
    write_done = frame_clean && frame == FRAME_DATA && is_write(cmd) && page_mask != 16'h0000;
    unique case (bp)
      2'h0: page_locked = 1'b0;
      2'h1: page_locked = addr >= QUARTER_BASE;
      2'h2: page_locked = addr >= HALF_BASE;
      default: page_locked = 1'b1;
    endcase
    write_ok = cs_rise && write_done && write_latch_flag && wp_f && !busy && !page_locked;
    status_write_cmd_ok = cs_rise && status_write_cmd_done && write_latch_flag && wp_f && !busy;
  end

  // latch, protect bits and self-timed cycle
  always_comb begin
    next_wel = write_latch_flag;
    next_busy = busy;
    next_bp = bp;
    next_wcnt = wcnt;
    mem_we = 1'b0;
    if (busy) begin
      if (wcnt == 17'h00000) begin
        next_busy = 1'b0;
        next_wel = 1'b0;
      end else begin
        next_wcnt = wcnt - 17'h00001;
      end
    end
    if (cs_rise) begin
      if (set_write_latch_cmd_done) begin
        next_wel = 1'b1;
      end
      if (clear_write_latch_cmd_done || status_write_cmd_ok || write_ok) begin
        next_wel = 1'b0;
      end
      if (write_ok || status_write_cmd_ok) begin
        next_busy = 1'b1;
        next_wcnt = 17'(WRITE_CYCLES - 1);
        mem_we = write_ok;
      end
      if (status_write_cmd_ok) begin
        next_bp = sr_data;
      end
    end
    if (!wp_f) begin
      next_wel = 1'b0;
    end
  end

  // protect bits stand in for non-volatile cells; reset models erased state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      write_latch_flag <= 1'b0;
      busy <= 1'b0;
      bp <= PROT_RESET;
      wcnt <= 17'h00000;
    end else begin
      write_latch_flag <= next_wel;
      busy <= next_busy;
      bp <= next_bp;
      wcnt <= next_wcnt;
    end
  end

  // page bytes marked in page_mask committed at cycle start while the link sits idle
  always_ff @(posedge MCLK) begin
    if (mem_we) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_mask[i]) begin
          mem[{addr[8:4], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // output enable follows filtered select and pause
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SO_OE <= 1'b0;
    end else begin
      SO_OE <= !cs_f && hold_f;
    end
  end

  // checks
  sequence s_commit;
    cs_rise && (write_ok || status_write_cmd_ok);
  endsequence

  sequence s_running;
    busy && wcnt == 17'(WRITE_CYCLES - 1);
  endsequence

  property p_write_start;
    @(posedge MCLK) disable iff (!RST_N) s_commit |=> s_running ##1 busy;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write cycle not started");

  property p_cycle_end;
    @(posedge MCLK) disable iff (!RST_N)
      busy && wcnt == 17'h00000 |=> !busy && !write_latch_flag;
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("cycle end missed");

  property p_guard_clears;
    @(posedge MCLK) disable iff (!RST_N) !wp_f |=> !write_latch_flag;
  endproperty
  a_guard_clears: assert property (p_guard_clears) else $error("latch kept with guard low");

  property p_guard_refuses;
    @(posedge MCLK) disable iff (!RST_N) cs_rise && !wp_f && !busy |=> !busy;
  endproperty
  a_guard_refuses: assert property (p_guard_refuses) else $error("write under guard");

  property p_cycle_survives_guard;
    @(posedge MCLK) disable iff (!RST_N)
      busy && wcnt != 17'h00000 && !wp_f |=> busy;
  endproperty
  a_cycle_survives_guard: assert property (p_cycle_survives_guard) else $error("cycle cut");

  property p_latch_set;
    @(posedge MCLK) disable iff (!RST_N)
      cs_rise && set_write_latch_cmd_done && wp_f ##1 wp_f |-> write_latch_flag;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_clear;
    @(posedge MCLK) disable iff (!RST_N) cs_rise && clear_write_latch_cmd_done |=> !write_latch_flag;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_protect_only_by_status;
    @(posedge MCLK) disable iff (!RST_N) !$stable(bp) |-> $past(status_write_cmd_ok);
  endproperty
  a_protect_only_by_status: assert property (p_protect_only_by_status) else $error("bp moved");

  property p_release_output;
    @(posedge MCLK) disable iff (!RST_N) cs_f |=> !SO_OE;
  endproperty
  a_release_output: assert property (p_release_output) else $error("output not released");

  property p_page_wrap;
    @(posedge SCK) disable iff (CS_N)
      HOLD_N && page_we && addr[3:0] == 4'hf |=> addr[3:0] == 4'h0 && $stable(addr[8:4]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page wrap wrong");

  property p_read_wrap;
    @(posedge SCK) disable iff (CS_N)
      HOLD_N && !sof && frame == FRAME_DATA && bit_cnt == 3'h7 && is_read(cmd) && out_en
      && addr == LAST_ADDR |=> addr == 9'h000;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read wrap wrong");

endmodule

// ==== test/spi_master_model.sv ====
// master side of the serial memory link: frames, byte shifts, pause
// assumes the device samples SI on rising SCK and updates SO after falling SCK
`timescale 1ns/1ns
module spi_master_model (
  // link
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  // answer
  input wire logic so,
  input wire logic so_oe
);
  localparam int HALF = 80;
  logic held_oe;
  initial begin
    sck = 1'b0; // clock stands still outside frames
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    held_oe = 1'b0;
  end
  task automatic start();
    cs_n = 1'b0;
    #HALF;
  endtask
  task automatic stop();
    #HALF cs_n = 1'b1;
    si = ~si; // released line shows no stale value
    #(5*HALF);
  endtask
  // hold_at < 0: no pause; else pause after that many bits, clock low
  task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nbits; i--) begin
      if (7 - i == hold_at) begin
        hold_n = 1'b0;
        #HALF sck = 1'b1;
        #HALF sck = 1'b0;
        #(2*HALF) held_oe = so_oe;
        hold_n = 1'b1;
        #(4*HALF);
      end
      si = tx[i];
      #HALF rx[i] = so;
      sck = 1'b1;
      #HALF sck = 1'b0;
    end
  endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench of the serial memory command port through its link
// assumes spi_master_model drives the link; write cycle shortened by parameter
`timescale 1ns/1ns
module tb_top;
  import eeprom_cmd_pkg::*;
  localparam int WCYC = 200;
  logic MCLK, RST_N, WP_N, SCK, CS_N, SI, HOLD_N, SO, SO_OE;
  wire so_line;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] b;
  assign so_line = SO_OE ? SO : 1'bz; // undriven line must never match
  spi_eeprom_command_port #(.WRITE_CYCLES(WCYC)) u_spi_eeprom_command_port (
    .MCLK(MCLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N),
    .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE));
  spi_master_model u_spi_master_model (.sck(SCK), .cs_n(CS_N), .si(SI),
    .hold_n(HOLD_N), .so(so_line), .so_oe(SO_OE));
  initial MCLK = 1'b0;
  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic x(input logic [7:0] tx, output logic [7:0] rx);
    u_spi_master_model.xfer(tx, 8, -1, rx);
  endtask
  task automatic op(input logic [7:0] code);
    u_spi_master_model.start();
    x(code, b);
    u_spi_master_model.stop();
  endtask
  task automatic status(output logic [7:0] st);
    u_spi_master_model.start();
    x(STATUS_READ_OP, st);
    x(8'h00, st);
    u_spi_master_model.stop();
  endtask
  task automatic st_is(input logic [7:0] exp);
    status(b);
    chk(b, exp);
  endtask
  // polls the busy flag under a bounded count
  task automatic idle();
    logic [7:0] st;
    for (int i = 0; i < 20; i++) begin
      status(st);
      if (st[BUSY_POS] === 1'b0) return;
    end
    chk(st, 8'h00);
  endtask
  task automatic sw(input logic [7:0] v);
    op(SET_LATCH_OP);
    u_spi_master_model.start();
    x(STATUS_WRITE_OP, b);
    x(v, b);
    u_spi_master_model.stop();
    idle();
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d[$]);
    u_spi_master_model.start();
    x(WRITE_OP | {4'h0, a[8], 3'h0}, b);
    x(a[7:0], b);
    foreach (d[i]) x(d[i], b);
    u_spi_master_model.stop();
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e[$]);
    u_spi_master_model.start();
    x(READ_OP | {4'h0, a[8], 3'h0}, b);
    x(a[7:0], b);
    foreach (e[i]) begin
      x(8'h00, b);
      chk(b, e[i]);
    end
    u_spi_master_model.stop();
  endtask
  task automatic guard(input logic v);
    @(posedge MCLK);
    #5 WP_N = v;
  endtask
  initial begin
    RST_N = 1'b0;
    WP_N = 1'b1;
    repeat (6) @(posedge MCLK);
    #5 RST_N = 1'b1;
    repeat (5) @(posedge MCLK);
    #5;
    st_is(8'h00);
    op(SET_LATCH_OP);
    st_is(8'h02);
    op(CLEAR_LATCH_OP);
    st_is(8'h00);
    u_spi_master_model.start();
    u_spi_master_model.xfer(SET_LATCH_OP, 7, -1, b);
    u_spi_master_model.stop();
    st_is(8'h00);
    op(SET_LATCH_OP);
    wr(9'h000, '{8'h5a});
    status(b);
    chk(b & 8'h01, 8'h01);
    rd(9'h000, '{8'h00});
    idle();
    st_is(8'h00);
    op(SET_LATCH_OP);
    wr(9'h1ff, '{8'ha1, 8'hb2});
    idle();
    rd(9'h1ff, '{8'ha1, 8'h5a});
    rd(9'h1f0, '{8'hb2});
    wr(9'h000, '{8'h77});
    idle();
    rd(9'h000, '{8'h5a});
    op(SET_LATCH_OP);
    u_spi_master_model.start();
    x(WRITE_OP, b);
    x(8'h00, b);
    u_spi_master_model.xfer(8'h33, 4, -1, b);
    u_spi_master_model.stop();
    idle();
    rd(9'h000, '{8'h5a});
    op(SET_LATCH_OP);
    wr(9'h020, '{8'h3c});
    guard(1'b0);
    status(b);
    chk(b & 8'h01, 8'h01);
    idle();
    guard(1'b1);
    rd(9'h020, '{8'h3c});
    op(SET_LATCH_OP);
    guard(1'b0);
    st_is(8'h00);
    op(SET_LATCH_OP);
    st_is(8'h00);
    wr(9'h000, '{8'h66});
    idle();
    rd(9'h000, '{8'h5a});
    guard(1'b1);
    sw(8'hff);
    st_is(8'h0c);
    op(SET_LATCH_OP);
    wr(9'h000, '{8'h11});
    idle();
    rd(9'h000, '{8'h5a});
    sw(8'h04);
    op(SET_LATCH_OP);
    wr(9'h1ff, '{8'h99});
    idle();
    rd(9'h1ff, '{8'ha1});
    op(SET_LATCH_OP);
    wr(9'h17f, '{8'hc3});
    idle();
    rd(9'h17f, '{8'hc3});
    st_is(8'h04);
    sw(8'h08);
    st_is(8'h08);
    op(SET_LATCH_OP);
    wr(9'h1ff, '{8'h55});
    op(SET_LATCH_OP);
    wr(9'h0ff, '{8'h3e});
    idle();
    rd(9'h1ff, '{8'ha1});
    rd(9'h0ff, '{8'h3e});
    u_spi_master_model.start();
    x(READ_OP | 8'h08, b);
    x(8'hff, b);
    u_spi_master_model.xfer(8'h00, 8, 4, b);
    chk(b, 8'ha1);
    chk({7'h00, u_spi_master_model.held_oe}, 8'h00);
    u_spi_master_model.stop();
    test_done();
  end
endmodule
